/* File: verilog/hcd_pkg.sv */
`default_nettype none
package hcd_pkg;
	typedef logic [15:0] hcd_word_t;
	typedef logic [7:0] hcd_byte_t;

	localparam int RF_DEPTH = 32;
	localparam int BYTE_MSB = 7;
	localparam int NIB_BIT = 4;
	localparam int PROD_MSB = 15;

	localparam hcd_word_t RESET_PC = 16'h0000;
	// top of internal sram; stack starts here after reset
	localparam hcd_word_t SP_RESET = 16'h3FFF;
	localparam hcd_word_t PC_STEP = 16'h0001;
	localparam hcd_word_t SP_ONE = 16'h0001;
	localparam hcd_word_t SP_TWO = 16'h0002;
	localparam hcd_word_t NOP_WORD = 16'h0000;

	localparam hcd_word_t IO_SHORT_TOP = 16'h0040;
	localparam hcd_word_t IO_BIT_TOP = 16'h0020;
	localparam hcd_word_t NVM_BASE = 16'h1000;
	localparam hcd_word_t SRAM_BASE = 16'h1800;
	localparam hcd_word_t FLASH_BASE = 16'h8000;
	localparam hcd_word_t SPL_ADDR = 16'h003D;
	localparam hcd_word_t SPH_ADDR = 16'h003E;
	localparam hcd_word_t FLAGS_ADDR = 16'h003F;

	localparam logic [4:0] PTR_X = 5'h1A;
	localparam logic [4:0] PTR_Y = 5'h1C;
	localparam logic [4:0] PTR_Z = 5'h1E;
	localparam logic [4:0] PAIR_STEP = 5'h01;
	localparam logic [4:0] MUL_LO = 5'h00;
	localparam logic [4:0] MUL_HI = 5'h01;

	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam hcd_byte_t FLAGS_RESET = 8'h00;

	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_ADD = 4'h1;
	localparam logic [3:0] OP_SUB = 4'h2;
	localparam logic [3:0] OP_AND = 4'h3;
	localparam logic [3:0] OP_OR = 4'h4;
	localparam logic [3:0] OP_EOR = 4'h5;
	localparam logic [3:0] OP_MOV = 4'h6;
	localparam logic [3:0] OP_MUL = 4'h7;
	localparam logic [3:0] OP_FMUL = 4'h8;
	localparam logic [3:0] OP_LDI = 4'h9;
	localparam logic [3:0] OP_SUBI = 4'hA;
	localparam logic [3:0] OP_ANDI = 4'hB;
	localparam logic [3:0] OP_ORI = 4'hC;
	localparam logic [3:0] OP_MEM = 4'hD;
	localparam logic [3:0] OP_IO = 4'hE;
	localparam logic [3:0] OP_SYS = 4'hF;

	localparam logic [1:0] MV_SS = 2'h1;
	localparam logic [1:0] PSEL_PM = 2'h3;
	localparam logic [1:0] SUB_BIT = 2'h0;
	localparam logic [1:0] SUB_SKIP = 2'h1;
	localparam logic [1:0] SUB_JMP = 2'h2;
	localparam logic [1:0] STK_RET = 2'h0;
	localparam logic [1:0] STK_PUSH = 2'h1;
	localparam logic [1:0] STK_POP = 2'h2;

	typedef enum logic [1:0] {
		RG_IO = 2'h0,
		RG_NVM = 2'h1,
		RG_SRAM = 2'h2,
		RG_FLASH = 2'h3
	} hcd_region_e;

	typedef enum logic [4:0] {
		ST_EXEC = 5'h01,
		ST_MUL2 = 5'h02,
		ST_FLASH = 5'h04,
		ST_CALL2 = 5'h08,
		ST_RET2 = 5'h10
	} hcd_state_e;

	function automatic hcd_region_e region_of(hcd_word_t a);
		if (a >= FLASH_BASE)
			return RG_FLASH;
		else if (a >= SRAM_BASE)
			return RG_SRAM;
		else if (a >= NVM_BASE)
			return RG_NVM;
		else
			return RG_IO;
	endfunction

	function automatic logic [4:0] f_ptr(logic [1:0] sel);
		if (sel == 2'h0)
			return PTR_X;
		else if (sel == 2'h1)
			return PTR_Y;
		else
			return PTR_Z;
	endfunction

	// instruction field layout
	function automatic logic [3:0] f_op(hcd_word_t w);
		return w[15:12];
	endfunction
	function automatic logic [4:0] f_rd(hcd_word_t w);
		return w[9:5];
	endfunction
	function automatic logic [4:0] f_rr(hcd_word_t w);
		return w[4:0];
	endfunction
	function automatic logic [4:0] f_rdi(hcd_word_t w);
		return {1'b1, w[11:8]};
	endfunction
	function automatic hcd_byte_t f_imm(hcd_word_t w);
		return w[7:0];
	endfunction
	function automatic logic [1:0] f_sub(hcd_word_t w);
		return w[11:10];
	endfunction
	function automatic logic [1:0] f_psel(hcd_word_t w);
		return w[10:9];
	endfunction
	function automatic logic [4:0] f_mreg(hcd_word_t w);
		return w[8:4];
	endfunction
	function automatic logic [4:0] f_ioreg(hcd_word_t w);
		return w[10:6];
	endfunction
	function automatic logic [5:0] f_ioa(hcd_word_t w);
		return w[5:0];
	endfunction
	function automatic logic [4:0] f_bita(hcd_word_t w);
		return w[7:3];
	endfunction
	function automatic logic [2:0] f_bitn(hcd_word_t w);
		return w[2:0];
	endfunction
	function automatic logic [1:0] f_stk(hcd_word_t w);
		return w[9:8];
	endfunction
	function automatic logic f_b11(hcd_word_t w);
		return w[11];
	endfunction
	function automatic logic f_b9(hcd_word_t w);
		return w[9];
	endfunction
endpackage
`default_nettype wire

/* File: verilog/hcd_core.sv */
`timescale 1ns/100ps
`default_nettype none
module hcd_core (
	input wire logic mclk,
	input wire logic rst_b,
	output logic [15:0] prog_addr,
	input wire logic [15:0] prog_rdata,
	output logic [15:0] dmem_addr,
	output logic [7:0] dmem_wdata,
	output logic dmem_we,
	output logic dmem_re,
	output hcd_pkg::hcd_region_e dmem_region,
	input wire logic [7:0] dmem_rdata,
	output logic [7:0] result_flags_register,
	output logic [15:0] stack_pointer,
	output logic [15:0] fetch_address_counter
);
	import hcd_pkg::*;

	hcd_state_e st_q, st_d;
	hcd_byte_t rf [0:RF_DEPTH-1];
	hcd_word_t ir_q, ir_d, pc_q, pc_d, sp_q, sp_d, tgt_q, tgt_d;
	hcd_word_t faddr_q, faddr_d, bus_a;
	hcd_byte_t result_flags_register_q, result_flags_register_d, hi_q, hi_d, bus_wd, rf_wd, alu_res, alu_result_flags_register;
	logic [16:0] prod_q, prod_d;
	logic [4:0] pend_q, pend_d, rf_wa;
	logic rf_we, pair_we, bus_wr, bus_rd, started_q;

	// decode of the instruction in execution
	wire [3:0] op = f_op(ir_q);
	wire is_alu = (op >= OP_ADD) && (op <= OP_MOV);
	wire is_imm = (op >= OP_LDI) && (op <= OP_ORI);
	wire is_mul = (op == OP_MUL) || (op == OP_FMUL);
	wire is_sys = (op == OP_SYS);
	wire sub_op = (op == OP_SUB) || (op == OP_SUBI);
	wire arith = (op == OP_ADD) || sub_op;
	wire flag_op = (is_alu || is_imm) && (op != OP_MOV) && (op != OP_LDI);
	wire is_bit = is_sys && (f_sub(ir_q) == SUB_BIT);
	wire is_skip = is_sys && (f_sub(ir_q) == SUB_SKIP);
	wire is_jmp = is_sys && (f_sub(ir_q) == SUB_JMP);
	wire is_call = is_jmp && f_b9(ir_q);
	wire is_stk = is_sys && (f_sub(ir_q) > SUB_JMP);
	wire is_push = is_stk && (f_stk(ir_q) == STK_PUSH);
	wire is_pop = is_stk && (f_stk(ir_q) == STK_POP);
	wire is_ret = is_stk && (f_stk(ir_q) == STK_RET);
	wire exec = (st_q == ST_EXEC);

	// two read ports feed the alu, one write port takes the result
	wire [4:0] alu_dst = is_imm ? f_rdi(ir_q) : f_rd(ir_q);
	wire [7:0] opa = rf[alu_dst];
	wire [7:0] opb = is_imm ? f_imm(ir_q) : rf[f_rr(ir_q)];
	wire [8:0] sum9 = sub_op ? {1'b0, opa} - {1'b0, opb}
		: {1'b0, opa} + {1'b0, opb};

	always_comb begin
		case (op)
		OP_ADD, OP_SUB, OP_SUBI: alu_res = sum9[BYTE_MSB:0];
		OP_AND, OP_ANDI: alu_res = opa & opb;
		OP_OR, OP_ORI: alu_res = opa | opb;
		OP_EOR: alu_res = opa ^ opb;
		default: alu_res = opb;
		endcase
	end

	// result flags follow each arithmetic and logic result
	always_comb begin
		alu_result_flags_register = result_flags_register_q;
		alu_result_flags_register[FL_V] = 1'b0;
		if (arith) begin
			alu_result_flags_register[FL_C] = sum9[BYTE_MSB+1];
			alu_result_flags_register[FL_H] = opa[NIB_BIT] ^ opb[NIB_BIT] ^ sum9[NIB_BIT];
			alu_result_flags_register[FL_V] = (sub_op ^ (opa[BYTE_MSB] == opb[BYTE_MSB]))
				&& (sum9[BYTE_MSB] != opa[BYTE_MSB]);
		end
		alu_result_flags_register[FL_N] = alu_res[BYTE_MSB];
		alu_result_flags_register[FL_Z] = (alu_res == '0);
		alu_result_flags_register[FL_S] = alu_res[BYTE_MSB] ^ alu_result_flags_register[FL_V];
	end

	// multiplier: sign of each operand chosen by variant
	wire [1:0] mvar = f_sub(ir_q);
	wire msa = (mvar != 2'h0);
	wire msb = (mvar == MV_SS);
	wire [7:0] ma = rf[f_rd(ir_q)];
	wire [7:0] mb = rf[f_rr(ir_q)];
	wire signed [17:0] mfull = $signed({msa & ma[BYTE_MSB], ma})
		* $signed({msb & mb[BYTE_MSB], mb});
	wire [15:0] mraw = mfull[PROD_MSB:0];
	wire [15:0] mword = (op == OP_FMUL) ? {mraw[PROD_MSB-1:0], 1'b0}
		: mraw;

	// pointer pairs and data-space flash window
	wire [4:0] ptr_lo = f_ptr(f_psel(ir_q));
	wire [15:0] ptr = {rf[ptr_lo + PAIR_STEP], rf[ptr_lo]};
	wire program_memory_load = (f_psel(ir_q) == PSEL_PM);
	wire mem_st = f_b11(ir_q);
	wire mem_flash = !mem_st && (program_memory_load || (region_of(ptr) == RG_FLASH));
	wire [15:0] flash_byte = program_memory_load ? ptr : ptr - FLASH_BASE;
	wire [15:0] io_a = 16'(f_ioa(ir_q));
	wire [15:0] bit_a = 16'(f_bita(ir_q));
	wire [2:0] bitn = f_bitn(ir_q);
	wire [15:0] ret_addr = pc_q + PC_STEP;

	// data address is settled before read data is used
	always_comb begin
		if (st_q == ST_RET2)
			bus_a = sp_q + SP_ONE;
		else if (!exec)
			bus_a = sp_q;
		else if (op == OP_MEM)
			bus_a = ptr;
		else if (op == OP_IO)
			bus_a = io_a;
		else if (is_bit || is_skip)
			bus_a = bit_a;
		else if (is_pop || is_ret)
			bus_a = sp_q + SP_ONE;
		else
			bus_a = sp_q;
	end

	// stack pointer and flags answer inside io space
	wire hit_spl = (bus_a == SPL_ADDR);
	wire hit_sph = (bus_a == SPH_ADDR);
	wire hit_flg = (bus_a == FLAGS_ADDR);
	wire int_hit = hit_spl || hit_sph || hit_flg;
	wire [7:0] int_rd = hit_spl ? sp_q[7:0] : hit_sph ? sp_q[15:8] : result_flags_register_q;
	wire [7:0] rdata = int_hit ? int_rd : dmem_rdata;
	wire [7:0] bmask = 8'h01 << bitn;

	always_comb begin
		st_d = ST_EXEC;
		pc_d = pc_q + PC_STEP;
		ir_d = prog_rdata;
		sp_d = sp_q;
		result_flags_register_d = result_flags_register_q;
		tgt_d = tgt_q;
		hi_d = hi_q;
		faddr_d = faddr_q;
		pend_d = pend_q;
		prod_d = prod_q;
		rf_we = 1'b0;
		rf_wa = alu_dst;
		rf_wd = alu_res;
		pair_we = 1'b0;
		bus_wd = rf[f_rr(ir_q)];
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		case (st_q)
		ST_EXEC: begin
			if (is_alu || is_imm) begin
				rf_we = 1'b1;
				if (flag_op)
					result_flags_register_d = alu_result_flags_register;
			end else if (is_mul) begin
				prod_d = {mraw[PROD_MSB], mword};
				st_d = ST_MUL2;
			end else if (op == OP_MEM) begin
				rf_wa = f_mreg(ir_q);
				bus_wd = rf[f_mreg(ir_q)];
				if (mem_st) begin
					bus_wr = 1'b1;
				end else if (mem_flash) begin
					faddr_d = flash_byte;
					pend_d = f_mreg(ir_q);
					st_d = ST_FLASH;
				end else begin
					bus_rd = 1'b1;
					rf_we = 1'b1;
					rf_wd = rdata;
				end
			end else if (op == OP_IO) begin
				rf_wa = f_ioreg(ir_q);
				bus_wd = rf[f_ioreg(ir_q)];
				bus_wr = f_b11(ir_q);
				bus_rd = !f_b11(ir_q);
				rf_we = !f_b11(ir_q);
				rf_wd = rdata;
			end else if (is_bit) begin
				bus_rd = 1'b1;
				bus_wr = 1'b1;
				bus_wd = f_b9(ir_q) ? (rdata | bmask) : (rdata & ~bmask);
			end else if (is_skip) begin
				bus_rd = 1'b1;
				if (rdata[bitn] == f_b9(ir_q))
					ir_d = NOP_WORD;
			end else if (is_jmp) begin
				if (is_call) begin
					bus_wr = 1'b1;
					bus_wd = ret_addr[7:0];
					sp_d = sp_q - SP_ONE;
					tgt_d = prog_rdata;
					pc_d = pc_q;
					ir_d = ir_q;
					st_d = ST_CALL2;
				end else begin
					pc_d = prog_rdata;
					ir_d = NOP_WORD;
				end
			end else if (is_push) begin
				bus_wr = 1'b1;
				sp_d = sp_q - SP_ONE;
			end else if (is_pop) begin
				bus_rd = 1'b1;
				rf_we = 1'b1;
				rf_wa = f_rr(ir_q);
				rf_wd = rdata;
				sp_d = sp_q + SP_ONE;
			end else if (is_ret) begin
				bus_rd = 1'b1;
				hi_d = rdata;
				sp_d = sp_q + SP_ONE;
				pc_d = pc_q;
				ir_d = ir_q;
				st_d = ST_RET2;
			end
		end
		ST_MUL2: begin
			pc_d = pc_q;
			ir_d = ir_q;
			pair_we = 1'b1;
			result_flags_register_d[FL_C] = prod_q[PROD_MSB+1];
			result_flags_register_d[FL_Z] = (prod_q[PROD_MSB:0] == '0);
		end
		ST_FLASH: begin
			pc_d = pc_q;
			ir_d = ir_q;
			rf_we = 1'b1;
			rf_wa = pend_q;
			rf_wd = faddr_q[0] ? prog_rdata[15:8] : prog_rdata[7:0];
		end
		ST_CALL2: begin
			bus_wr = 1'b1;
			bus_wd = ret_addr[15:8];
			sp_d = sp_q - SP_ONE;
			pc_d = tgt_q;
			ir_d = NOP_WORD;
		end
		default: begin
			bus_rd = 1'b1;
			sp_d = sp_q + SP_ONE;
			pc_d = {hi_q, rdata};
			ir_d = NOP_WORD;
		end
		endcase
		if (bus_wr && hit_spl)
			sp_d[7:0] = bus_wd;
		if (bus_wr && hit_sph)
			sp_d[15:8] = bus_wd;
		if (bus_wr && hit_flg)
			result_flags_register_d = bus_wd;
	end

	// program bus lends itself to flash data reads for one cycle
	assign prog_addr = (st_q == ST_FLASH) ? {1'b0, faddr_q[15:1]} : pc_q;
	assign dmem_addr = bus_a;
	assign dmem_wdata = bus_wd;
	assign dmem_region = region_of(bus_a);
	assign dmem_we = bus_wr && !int_hit && (dmem_region != RG_FLASH);
	assign dmem_re = bus_rd && !int_hit;
	assign result_flags_register = result_flags_register_q;
	assign stack_pointer = sp_q;
	assign fetch_address_counter = pc_q;

	// single undivided clock for the whole core
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= ST_EXEC;
			pc_q <= RESET_PC;
			ir_q <= NOP_WORD;
			sp_q <= SP_RESET;
			result_flags_register_q <= FLAGS_RESET;
			started_q <= 1'b0;
		end else begin
			st_q <= st_d;
			pc_q <= pc_d;
			ir_q <= ir_d;
			sp_q <= sp_d;
			result_flags_register_q <= result_flags_register_d;
			started_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tgt_q <= '0;
			hi_q <= '0;
			faddr_q <= '0;
			pend_q <= '0;
			prod_q <= '0;
		end else begin
			tgt_q <= tgt_d;
			hi_q <= hi_d;
			faddr_q <= faddr_d;
			pend_q <= pend_d;
			prod_q <= prod_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (rf_we)
			rf[rf_wa] <= rf_wd;
		if (pair_we) begin
			rf[MUL_LO] <= prod_q[7:0];
			rf[MUL_HI] <= prod_q[15:8];
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	sequence s_mul_start;
		exec && is_mul;
	endsequence
	sequence s_mul_done;
		(st_q == ST_MUL2) ##1 exec;
	endsequence
	sequence s_call;
		exec && is_call;
	endsequence

	AST_RESET_FETCH: assert property (!started_q |-> prog_addr == RESET_PC)
		else $error("first fetch not at reset address");
	AST_RESET_SP: assert property (!started_q |-> sp_q == SP_RESET)
		else $error("stack pointer not at top of sram");
	AST_FETCH_STEP: assert property (exec && (is_alu || is_imm) |=>
		pc_q == $past(pc_q) + PC_STEP && ir_q == $past(prog_rdata))
		else $error("prefetch did not advance");
	AST_ALU_WB: assert property (exec && (is_alu || is_imm) |=>
		rf[$past(alu_dst)] == $past(alu_res))
		else $error("alu result not written back");
	AST_ZERO_FLAG: assert property (exec && flag_op |=>
		result_flags_register_q[FL_Z] == ($past(alu_res) == '0))
		else $error("zero flag wrong");
	AST_MUL_TWO: assert property (s_mul_start |=> s_mul_done)
		else $error("multiply not two cycles");
	AST_MUL_RESULT: assert property (s_mul_start |-> ##2
		{rf[MUL_HI], rf[MUL_LO]} == $past(mword, 2))
		else $error("product wrong");
	AST_CALL_SP: assert property (s_call |-> ##2
		sp_q == $past(sp_q, 2) - SP_TWO && pc_q == $past(prog_rdata, 2))
		else $error("call did not push two bytes");
	AST_PUSH: assert property (exec && is_push |=>
		sp_q == $past(sp_q) - SP_ONE)
		else $error("push did not decrement");
	AST_POP: assert property (exec && is_pop |=>
		sp_q == $past(sp_q) + SP_ONE)
		else $error("pop did not increment");
	AST_SHORT_IO: assert property (exec && op == OP_IO |->
		dmem_addr < IO_SHORT_TOP)
		else $error("short io outside low range");
	AST_BIT_IO: assert property (exec && (is_bit || is_skip) |->
		dmem_addr < IO_BIT_TOP)
		else $error("bit op outside low range");
endmodule
`default_nettype wire

/* File: tb/hcd_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// program and data memories facing the core, both read combinationally
module hcd_mem_model (
	input wire logic mclk,
	input wire logic [15:0] prog_addr,
	output logic [15:0] prog_rdata,
	input wire logic [15:0] dmem_addr,
	input wire logic [7:0] dmem_wdata,
	input wire logic dmem_we,
	input wire logic dmem_re,
	output logic [7:0] dmem_rdata
);
	logic [15:0] prog [0:4095];
	logic [7:0] data [0:65535];
	logic [7:0] junk_q;
	initial begin
		junk_q = 8'h5A;
		for (int i = 0; i < 4096; i++)
			prog[i] = 16'h0000;
		for (int i = 0; i < 65536; i++)
			data[i] = 8'h00;
	end
	// unselected data lines show a pattern that changes every cycle
	always @(posedge mclk) begin
		junk_q <= ~junk_q;
		if (dmem_we)
			data[dmem_addr] <= dmem_wdata;
	end
	assign prog_rdata = prog[prog_addr[11:0]];
	assign dmem_rdata = (dmem_re | dmem_we) ? data[dmem_addr] : junk_q;
endmodule
`default_nettype wire

/* File: tb/harvard_cpu_core_datapath_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module harvard_cpu_core_datapath_bench;
	import hcd_pkg::*;
	typedef struct packed {
		logic [3:0] op;
		logic [1:0] vsel;
		logic [7:0] a;
		logic [7:0] b;
		logic [15:0] res;
		logic [7:0] fmask;
		logic [7:0] fexp;
	} hcd_row_s;
	hcd_row_s rows [0:16] = '{
		'{OP_ADD, 2'h0, 8'h7F, 8'h01, 16'h0080, 8'h07, 8'h04},
		'{OP_ADD, 2'h0, 8'hFF, 8'h01, 16'h0000, 8'h07, 8'h03},
		'{OP_SUB, 2'h0, 8'h10, 8'h20, 16'h00F0, 8'h07, 8'h05},
		'{OP_SUB, 2'h0, 8'h33, 8'h33, 16'h0000, 8'h07, 8'h02},
		'{OP_AND, 2'h0, 8'hF0, 8'h0F, 16'h0000, 8'h0E, 8'h02},
		'{OP_OR, 2'h0, 8'h80, 8'h01, 16'h0081, 8'h0E, 8'h04},
		'{OP_EOR, 2'h0, 8'hAA, 8'hFF, 16'h0055, 8'h0E, 8'h00},
		'{OP_MOV, 2'h0, 8'h11, 8'h3C, 16'h003C, 8'h00, 8'h00},
		'{OP_LDI, 2'h0, 8'h11, 8'hC3, 16'h00C3, 8'h00, 8'h00},
		'{OP_SUBI, 2'h0, 8'h05, 8'h06, 16'h00FF, 8'h07, 8'h05},
		'{OP_ANDI, 2'h0, 8'h3C, 8'hC3, 16'h0000, 8'h0E, 8'h02},
		'{OP_ORI, 2'h0, 8'h00, 8'h00, 16'h0000, 8'h0E, 8'h02},
		'{OP_MUL, 2'h0, 8'hFF, 8'hFF, 16'hFE01, 8'h03, 8'h01},
		'{OP_MUL, 2'h1, 8'hFF, 8'h02, 16'hFFFE, 8'h03, 8'h01},
		'{OP_MUL, 2'h2, 8'hFE, 8'h03, 16'hFFFA, 8'h03, 8'h01},
		'{OP_MUL, 2'h0, 8'h00, 8'h55, 16'h0000, 8'h03, 8'h02},
		'{OP_FMUL, 2'h0, 8'h80, 8'h80, 16'h8000, 8'h03, 8'h00}
	};
	logic [15:0] bnd [0:5] = '{16'h0FFF, 16'h1000, 16'h17FF, 16'h1800,
		16'h7FFF, 16'h8000};
	logic mclk;
	logic rst_b;
	logic [15:0] prog_addr;
	logic [15:0] prog_rdata;
	logic [15:0] dmem_addr;
	logic [7:0] dmem_wdata;
	logic dmem_we;
	logic dmem_re;
	hcd_region_e dmem_region;
	logic [7:0] dmem_rdata;
	logic [7:0] result_flags_register;
	logic [15:0] stack_pointer;
	logic [15:0] fetch_address_counter;
	int failures;
	int total_checks;
	logic [15:0] wp;
	logic [15:0] halt;
	logic [15:0] ca;
	logic [15:0] base;

	hcd_core dut (.mclk, .rst_b, .prog_addr, .prog_rdata, .dmem_addr,
		.dmem_wdata, .dmem_we, .dmem_re, .dmem_region, .dmem_rdata,
		.result_flags_register, .stack_pointer, .fetch_address_counter);
	hcd_mem_model mem (.mclk, .prog_addr, .prog_rdata, .dmem_addr,
		.dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk8(input logic [7:0] seen, input logic [7:0] exp);
		check({8'h00, seen}, {8'h00, exp});
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic emit(input logic [15:0] w);
		mem.prog[wp[11:0]] = w;
		wp++;
	endtask
	// store a register through the x pointer
	task automatic put(input logic [4:0] r, input logic [15:0] a);
		emit({OP_LDI, 4'hA, a[7:0]});
		emit({OP_LDI, 4'hB, a[15:8]});
		emit({OP_MEM, 1'b1, 2'h0, r, 4'h0});
	endtask
	task automatic rdio(input logic [4:0] r, input logic [5:0] a);
		emit({OP_IO, 1'b0, r, a});
	endtask
	task automatic start;
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (5) @(posedge mclk);
		#1;
		check(fetch_address_counter, RESET_PC);
		check(prog_addr, RESET_PC);
		check(stack_pointer, SP_RESET);
		chk8(result_flags_register, FLAGS_RESET);
		chk8({7'h00, dmem_we}, 8'h00);
		@(posedge mclk);
		rst_b <= 1'b1;
	endtask
	function automatic logic [15:0] alu_word(input hcd_row_s r);
		if (r.op >= OP_LDI && r.op <= OP_ORI)
			return {r.op, 4'h0, r.b};
		return {r.op, r.vsel, 5'h10, 5'h11};
	endfunction
	function automatic logic [1:0] exp_region(input logic [15:0] a);
		if (a < 16'h1000)
			return 2'h0;
		if (a < 16'h1800)
			return 2'h1;
		if (a < 16'h8000)
			return 2'h2;
		return 2'h3;
	endfunction

	always @(negedge mclk) begin
		if (rst_b === 1'b1 && dmem_we === 1'b1) begin
			check({14'h0, dmem_region}, {14'h0, exp_region(dmem_addr)});
			check({15'h0, dmem_addr[15]}, 16'h0000);
		end
		if (rst_b === 1'b1 && dmem_re === 1'b1)
			check({15'h0, (dmem_addr[15:2] == 14'h000F)
				&& (dmem_addr[1:0] != 2'h0)}, 16'h0000);
	end

	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		final_report();
	end

	initial begin
		failures = 0;
		total_checks = 0;
		rst_b = 1'b0;
		@(posedge mclk);
		wp = 16'h0000;
		emit({OP_LDI, 4'h0, 8'h03});
		emit({OP_LDI, 4'h1, 8'h05});
		emit({OP_MUL, 2'h0, 5'h10, 5'h11});
		start();
		repeat (5) @(posedge mclk);
		#1;
		check(fetch_address_counter, 16'h0004);
		wp = 16'h0000;
		// flags captured by the bench right after each op
		foreach (rows[i]) begin
			emit({OP_LDI, 4'h0, rows[i].a});
			emit({OP_LDI, 4'h1, rows[i].b});
			emit(alu_word(rows[i]));
			rdio(5'h12, 6'h3F);
			base = 16'h2000 + 16'(4 * i);
			put(rows[i].op >= OP_MUL && rows[i].op <= OP_FMUL ? 5'h00 : 5'h10, base);
			put(5'h01, base + 16'h0001);
			put(5'h12, base + 16'h0002);
		end
		emit({OP_LDI, 4'h0, 8'hA5});
		emit({OP_IO, 1'b1, 5'h10, 6'h3C});
		rdio(5'h13, 6'h3C);
		put(5'h13, 16'h2100);
		emit({OP_IO, 1'b1, 5'h10, 6'h1F});
		emit({OP_SYS, 2'h0, 1'b1, 1'b0, 5'h1F, 3'h1});
		emit({OP_SYS, 2'h0, 1'b0, 1'b0, 5'h1F, 3'h7});
		emit({OP_SYS, 2'h1, 1'b1, 1'b0, 5'h1F, 3'h3});
		emit({OP_LDI, 4'h0, 8'h11});
		emit({OP_SYS, 2'h1, 1'b1, 1'b0, 5'h1F, 3'h0});
		emit({OP_LDI, 4'h0, 8'h22});
		put(5'h10, 16'h2101);
		foreach (bnd[i])
			put(5'h10, bnd[i]);
		emit({OP_LDI, 4'hA, 8'h01});
		emit({OP_LDI, 4'hB, 8'h80});
		emit({OP_MEM, 1'b0, 2'h0, 5'h17, 4'h0});
		put(5'h17, 16'h2102);
		emit({OP_LDI, 4'hE, 8'h02});
		emit({OP_LDI, 4'hF, 8'h00});
		emit({OP_MEM, 1'b0, 2'h3, 5'h18, 4'h0});
		put(5'h18, 16'h2103);
		emit({OP_LDI, 4'hC, 8'h04});
		emit({OP_LDI, 4'hD, 8'h21});
		emit({OP_MEM, 1'b1, 2'h1, 5'h10, 4'h0});
		emit({OP_LDI, 4'h0, 8'h5A});
		ca = wp;
		emit({OP_SYS, 2'h2, 1'b1, 9'h000});
		emit(16'h0000);
		rdio(5'h16, 6'h3D);
		put(5'h16, 16'h2110);
		halt = wp;
		emit({OP_SYS, 2'h2, 1'b0, 9'h000});
		emit(halt);
		mem.prog[ca[11:0] + 12'h001] = wp;
		rdio(5'h12, 6'h3D);
		put(5'h12, 16'h2111);
		emit({OP_SYS, 2'h3, 2'h1, 3'h0, 5'h10});
		rdio(5'h13, 6'h3D);
		put(5'h13, 16'h2112);
		emit({OP_SYS, 2'h3, 2'h2, 3'h0, 5'h14});
		put(5'h14, 16'h2113);
		rdio(5'h15, 6'h3D);
		put(5'h15, 16'h2114);
		emit({OP_SYS, 2'h3, 2'h0, 8'h00});
		start();
		repeat (6) @(posedge mclk);
		#1;
		check(fetch_address_counter, 16'h0006);
		for (int k = 0; k < 3000 && fetch_address_counter !== halt; k++)
			@(posedge mclk);
		repeat (10) @(posedge mclk);
		foreach (rows[i]) begin
			base = 16'h2000 + 16'(4 * i);
			chk8(mem.data[base], rows[i].res[7:0]);
			if (rows[i].op >= OP_MUL && rows[i].op <= OP_FMUL)
				chk8(mem.data[base + 16'h0001], rows[i].res[15:8]);
			chk8(mem.data[base + 16'h0002] & rows[i].fmask,
				rows[i].fexp);
		end
		chk8(mem.data[16'h003C], 8'hA5);
		chk8(mem.data[16'h2100], 8'hA5);
		chk8(mem.data[16'h001F], 8'h27);
		chk8(mem.data[16'h2101], 8'h11);
		for (int i = 0; i < 5; i++)
			chk8(mem.data[bnd[i]], 8'h11);
		chk8(mem.data[16'h8000], 8'h00);
		chk8(mem.data[16'h2102], mem.prog[0][15:8]);
		chk8(mem.data[16'h2103], mem.prog[1][7:0]);
		chk8(mem.data[16'h2104], 8'h11);
		chk8(mem.data[16'h2110], 8'hFF);
		chk8(mem.data[16'h2111], 8'hFD);
		chk8(mem.data[16'h2112], 8'hFC);
		chk8(mem.data[16'h2113], 8'h5A);
		chk8(mem.data[16'h2114], 8'hFD);
		chk8(mem.data[16'h3FFD], 8'h5A);
		base = ca + 16'h0002;
		chk8(mem.data[16'h3FFF], base[7:0]);
		chk8(mem.data[16'h3FFE], base[15:8]);
		check(stack_pointer, SP_RESET);
		final_report();
	end
endmodule
`default_nettype wire
